/* src/stsi_serial_in.v */
`timescale 1ns/1ns
`include "stsi_defines.vh"
// Function
// [R01] Left, I2S, right framing; 16/18/20/24 bits
// [R02] Capture data on rising bit clock
// [R03] Right-justified: select high is left
// [R04] Right-justified: MSB after 64-width bit clocks; code starts it after 32-width
// [R05] I2S default: select low is left
// [R06] I2S: MSB one bit clock late
// [R07] Left-justified: select high is left
// [R08] Left-justified: MSB right after transition
// [R09] Extra bits ignored; one word per channel
module stsi_serial_in #(
  parameter WORD_W = `STSI_WORD_W,
  parameter DEPTH  = `STSI_FIFO_DEPTH
) (
  // Clock and reset
  input  wire              clock,
  input  wire              resetn,
  // Configuration
  input  wire [1:0]        format_sel,
  input  wire [1:0]        width_sel,
  // Serial link
  input  wire              bit_clock,
  input  wire              channel_select,
  input  wire              serial_sample_data,
  // Encoder side
  output reg               sample_valid,
  input  wire              sample_ready,
  output reg  [WORD_W-1:0] sample_word,
  output reg               sample_left,
  output reg               overrun
);
  reg [1:0]        bck_sync_reg;
  reg [1:0]        sel_sync_reg;
  reg [1:0]        dat_sync_reg;
  reg              bck_last_reg;
  reg              sel_last_reg;
  reg [1:0]        fmt_reg;
  reg [1:0]        wid_reg;
  reg [5:0]        pos_reg;
  reg [5:0]        got_reg;
  reg [WORD_W-1:0] shift_reg;
  reg              left_reg;
  reg              push_reg;
  reg [WORD_W:0]   push_data_reg;
  reg [5:0]        pos_next;
  reg [5:0]        got_next;
  reg [WORD_W-1:0] shift_next;
  reg              push_next;
  reg [WORD_W:0]   push_data_next;
  wire             bck_rise;
  wire             sel_edge;
  wire             cur_left;
  wire [5:0]       nbits;
  wire [5:0]       first_pos;
  wire [5:0]       pos_now;
  wire             in_word;
  wire [1:0]       eff_fmt;
  wire [1:0]       eff_wid;
  wire [5:0]       got_now;
  wire             side_now;
  wire             word_done;
  wire             fifo_take;
  wire             f_ready;
  wire             f_valid;
  wire [WORD_W:0]  f_data;

  function [5:0] width_bits;
    input [1:0] w;
    begin
      case (w)
        `STSI_WID_16: width_bits = `STSI_BITS_16;
        `STSI_WID_18: width_bits = `STSI_BITS_18;
        `STSI_WID_20: width_bits = `STSI_BITS_20;
        default:      width_bits = `STSI_BITS_24;
      endcase
    end
  endfunction

  // FIFO pointer width; the FIFO wraps correctly only for a power-of-two depth
  function integer addr_bits;
    input integer depth;
    integer       v;
    begin
      addr_bits = 0;
      for (v = depth - 1; v > 0; v = v >> 1)
        addr_bits = addr_bits + 1;
    end
  endfunction

  localparam FIFO_AW = addr_bits(DEPTH);

  assign bck_rise  = bck_sync_reg[1] && !bck_last_reg;                    // [R02]
  assign sel_edge  = sel_sync_reg[1] != sel_last_reg;
  // New settings already govern the half frame their select edge opens
  assign eff_fmt   = sel_edge ? format_sel : fmt_reg;
  assign eff_wid   = sel_edge ? width_sel : wid_reg;
  assign nbits     = width_bits(eff_wid);                                  // [R01]
  // Polarity of the left channel per format
  assign cur_left  = (eff_fmt == `STSI_FMT_I2S) ? !sel_sync_reg[1] : sel_sync_reg[1]; // [R03] [R05] [R07]
  // Start bit offset within the half frame
  assign first_pos = (eff_fmt == `STSI_FMT_I2S) ? `STSI_I2S_DELAY :       // [R06]
                     (eff_fmt == `STSI_FMT_RJ)  ? (`STSI_HALF_BITS - nbits) : // [R04]
                     6'h00;                                                // [R08]
  // A bit edge coinciding with a select change is position zero
  assign pos_now   = sel_edge ? 6'h00 : pos_reg;
  assign got_now   = sel_edge ? 6'h00 : got_reg;
  assign side_now  = sel_edge ? cur_left : left_reg;
  assign in_word   = (pos_now >= first_pos) && (pos_now < first_pos + nbits); // [R09]
  assign word_done = in_word && (got_now + 6'h01 == nbits);               // [R09]
  assign fifo_take = !sample_valid || sample_ready;

  // Two stages on every link pin; the link runs from its own clock
  always @(posedge clock) begin
    if (!resetn) begin
      bck_sync_reg <= 2'h0;
      sel_sync_reg <= 2'h0;
      dat_sync_reg <= 2'h0;
    end else begin
      bck_sync_reg <= {bck_sync_reg[0], bit_clock};
      sel_sync_reg <= {sel_sync_reg[0], channel_select};
      dat_sync_reg <= {dat_sync_reg[0], serial_sample_data};
    end
  end

  always @(posedge clock) begin
    if (!resetn) begin
      bck_last_reg <= 1'b0;
      sel_last_reg <= 1'b0;
    end else begin
      bck_last_reg <= bck_sync_reg[1];
      if (bck_rise)
        sel_last_reg <= sel_sync_reg[1];
    end
  end

  // Format changes only take effect at a half-frame boundary
  always @(posedge clock) begin
    if (!resetn) begin
      fmt_reg  <= `STSI_FMT_I2S;                                           // [R05]
      wid_reg  <= `STSI_WID_24;
      left_reg <= 1'b0;
    end else if (bck_rise && sel_edge) begin
      fmt_reg  <= format_sel;                                              // [R01]
      wid_reg  <= width_sel;
      left_reg <= cur_left;                                                // [R03] [R05] [R07]
    end
  end

  always @* begin
    pos_next       = pos_reg;
    got_next       = got_reg;
    shift_next     = shift_reg;
    push_next      = 1'b0;
    push_data_next = push_data_reg;
    if (bck_rise) begin
      // Saturate so an overlong half frame never wraps into a window
      if (pos_now != `STSI_POS_MAX)
        pos_next = pos_now + 6'h01;
      got_next = got_now;
      if (in_word) begin                                                   // [R02] [R09]
        shift_next = {shift_reg[WORD_W-2:0], dat_sync_reg[1]};
        got_next   = got_now + 6'h01;
        if (word_done) begin                                               // [R09]
          push_next      = 1'b1;
          // Left-align the word so its MSB sits at the top bit
          push_data_next = {side_now, shift_next << (WORD_W[5:0] - nbits)};
        end
      end
    end
  end

  always @(posedge clock) begin
    if (!resetn) begin
      pos_reg       <= 6'h00;
      got_reg       <= 6'h00;
      shift_reg     <= {WORD_W{1'b0}};
      push_reg      <= 1'b0;
      push_data_reg <= {(WORD_W+1){1'b0}};
    end else begin
      pos_reg       <= pos_next;
      got_reg       <= got_next;
      shift_reg     <= shift_next;
      push_reg      <= push_next;
      push_data_reg <= push_data_next;
    end
  end

  // A word offered to a full FIFO is lost; flag it for one cycle
  always @(posedge clock) begin
    if (!resetn)
      overrun <= 1'b0;
    else
      overrun <= push_reg && !f_ready;                                    // [R09]
  end

  // Encoder stalls back up into the FIFO; a full FIFO drops the word and flags it
  stsi_fifo #(
    .WIDTH (WORD_W+1),
    .DEPTH (DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clock     (clock),
    .resetn    (resetn),
    .in_valid  (push_reg),
    .in_ready  (f_ready),
    .in_data   (push_data_reg),
    .out_valid (f_valid),
    .out_ready (fifo_take),
    .out_data  (f_data)
  );

  always @(posedge clock) begin
    if (!resetn) begin
      sample_valid <= 1'b0;
      sample_word  <= {WORD_W{1'b0}};
      sample_left  <= 1'b0;
    end else if (fifo_take) begin
      sample_valid <= f_valid;
      if (f_valid) begin
        sample_word <= f_data[WORD_W-1:0];
        sample_left <= f_data[WORD_W];
      end
    end
  end
endmodule // stsi_serial_in

/* src/stsi_defines.vh */
`ifndef STSI_DEFINES_VH
`define STSI_DEFINES_VH
`define STSI_FMT_LJ      2'h0
`define STSI_FMT_I2S     2'h1
`define STSI_FMT_RJ      2'h2
`define STSI_WID_16      2'h0
`define STSI_WID_18      2'h1
`define STSI_WID_20      2'h2
`define STSI_WID_24      2'h3
`define STSI_BITS_16     6'h10
`define STSI_BITS_18     6'h12
`define STSI_BITS_20     6'h14
`define STSI_BITS_24     6'h18
`define STSI_HALF_BITS   6'h20
`define STSI_I2S_DELAY   6'h01
`define STSI_POS_MAX     6'h3f
`define STSI_WORD_W      24
`define STSI_FIFO_DEPTH  16
`endif

/* src/stsi_fifo.v */
`timescale 1ns/1ns
module stsi_fifo #(
  parameter WIDTH = 25,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire             clock,
  input  wire             resetn,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ptr_reg;
  reg [AW:0]      rd_ptr_reg;
  wire            empty;
  wire            full;
  assign empty     = (wr_ptr_reg == rd_ptr_reg);
  assign full      = (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]) && (wr_ptr_reg[AW] != rd_ptr_reg[AW]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr_reg[AW-1:0]];
  always @(posedge clock) begin
    if (in_valid && !full)
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
  end
  always @(posedge clock) begin
    if (!resetn) begin
      wr_ptr_reg <= {(AW+1){1'b0}};
      rd_ptr_reg <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && !full)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (out_ready && !empty)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
endmodule // stsi_fifo

/* verif/stsi_serial_in_sva.sv */
`timescale 1ns/1ns
`include "stsi_defines.vh"
module stsi_serial_in_sva #(
  parameter WORD_W = 24,
  parameter DEPTH  = 16
) (
  input wire              clock,
  input wire              resetn,
  input wire [1:0]        width_sel,
  input wire              sample_valid,
  input wire              sample_ready,
  input wire [WORD_W-1:0] sample_word,
  input wire              sample_left,
  input wire              overrun
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence stall_s; sample_valid && !sample_ready; endsequence
  sequence narrow_s; sample_valid && width_sel == `STSI_WID_16; endsequence
  reset_flags_a: assert property ($rose(resetn) |-> !sample_valid && !overrun) else $error("flags after reset");
  reset_word_a: assert property ($rose(resetn) |-> sample_word == 0 && !sample_left) else $error("word after reset");
  valid_hold_a: assert property (stall_s |=> sample_valid) else $error("valid dropped");
  word_hold_a: assert property (stall_s |=> $stable(sample_word)) else $error("word changed");
  side_hold_a: assert property (stall_s |=> $stable(sample_left)) else $error("side changed");
  overrun_pulse_a: assert property (overrun |=> !overrun) else $error("overrun too long");
  overrun_full_a: assert property (overrun |-> $past(sample_valid)) else $error("overrun while empty");
  narrow_zero_a: assert property (narrow_s |-> sample_word[7:0] == 8'h00) else $error("narrow tail set");
endmodule // stsi_serial_in_sva
bind stsi_serial_in stsi_serial_in_sva #(.WORD_W(WORD_W), .DEPTH(DEPTH)) u_sva (.clock(clock), .resetn(resetn),
  .width_sel(width_sel), .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_word(sample_word),
  .sample_left(sample_left), .overrun(overrun));

/* verif/stsi_src_model.sv */
`timescale 1ns/1ns
module stsi_src_model (
  output reg bit_clock,
  output reg channel_select,
  output reg serial_sample_data
);
  integer h, p, s;
  initial begin
    bit_clock = 1'b0;
    channel_select = 1'b0;
    serial_sample_data = 1'b0;
  end
  // Lead-in bit forces a select edge even when polarity flips between formats
  task send(input [1:0] fmt, input [5:0] n, input [23:0] lw, input [23:0] rw);
    reg lvl;
    begin
      lvl = (fmt != 2'h1);
      s = (fmt == 2'h1) ? 1 : (fmt == 2'h2) ? 32 - n : 0;
      for (h = -1; h < 2; h = h + 1)
        for (p = (h < 0) ? 31 : 0; p < 32; p = p + 1) begin
          channel_select = (h == 0) ? lvl : !lvl;
          serial_sample_data = (h >= 0 && p >= s && p < s + n) ? (h == 0 ? lw[23-p+s] : rw[23-p+s])
                                                                : !serial_sample_data;
          #400 bit_clock = 1'b1;
          #400 bit_clock = 1'b0;
        end
    end
  endtask
endmodule // stsi_src_model

/* verif/stsi_serial_in_tb.sv */
`timescale 1ns/1ns
module stsi_serial_in_tb;
  reg         clock, resetn, sample_ready, hold_off;
  reg  [1:0]  format_sel, width_sel;
  wire        bit_clock, channel_select, serial_sample_data, sample_valid, sample_left, overrun;
  wire [23:0] sample_word;
  reg  [24:0] exp_q[$];
  reg  [24:0] e;
  reg  [23:0] lw, rw;
  reg  [5:0]  n;
  integer     seed, mismatches, cmp_count, overruns, f, w;
  stsi_serial_in u_dut (.clock(clock), .resetn(resetn), .format_sel(format_sel), .width_sel(width_sel),
    .bit_clock(bit_clock), .channel_select(channel_select), .serial_sample_data(serial_sample_data),
    .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_word(sample_word),
    .sample_left(sample_left), .overrun(overrun));
  stsi_src_model u_src (.bit_clock(bit_clock), .channel_select(channel_select),
    .serial_sample_data(serial_sample_data));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(negedge clock) sample_ready <= !hold_off && (($random(seed) & 3) != 0);
  task check(input [79:0] what, input [24:0] seen, input [24:0] want);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== want) begin
        mismatches = mismatches + 1;
        $display("mismatch %0s expected %h seen %h", what, want, seen);
      end
    end
  endtask
  always @(posedge clock) begin
    if (overrun === 1'b1) overruns = overruns + 1;
    if (sample_valid === 1'b1 && sample_ready === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 25'bx;
      check("word", {sample_left, sample_word}, e);
    end
  end
  task frame;
    begin
      lw = $random(seed);
      rw = $random(seed);
      n = (width_sel == 2'h3) ? 6'h18 : 6'h10 + {3'h0, width_sel, 1'b0};
      exp_q.push_back({1'b1, lw & ~(24'hffffff >> n)});
      exp_q.push_back({1'b0, rw & ~(24'hffffff >> n)});
      u_src.send(format_sel, n, lw, rw);
    end
  endtask
  task conclude;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    seed = 32'h6ada71c0;
    mismatches = 0;
    cmp_count = 0;
    overruns = 0;
    resetn = 1'b0;
    hold_off = 1'b0;
    format_sel = 2'h1;
    width_sel = 2'h3;
    repeat (3) @(posedge clock);
    @(negedge clock) resetn = 1'b1;
    for (f = 0; f < 4; f = f + 1)
      for (w = 0; w < 4; w = w + 1) begin
        @(negedge clock);
        format_sel = f;
        width_sel = w;
        repeat (2) frame;
        repeat (40) @(posedge clock);
        $display("test format %0d width %0d done", f, w);
      end
    // Output register plus 16 entries hold 17 words, so the 18th is lost
    @(negedge clock);
    hold_off = 1'b1;
    repeat (9) frame;
    hold_off = 1'b0;
    repeat (80) @(posedge clock);
    check("overruns", 25'(overruns), 25'h1);
    check("dropped", 25'(exp_q.size()), 25'h1);
    $display("test overrun done");
    conclude;
  end
  initial begin
    #3000000;
    mismatches = mismatches + 1;
    conclude;
  end
endmodule // stsi_serial_in_tb
